//--- gpc_cfg.svh
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH
// Behaviour
// - Bit 31 always reads zero
// - Bit 30 shuts PLLs in active L1
// - Device-state L1 always shuts PLLs off
// - Bit 29 enables active L1 upstream
// - Bit 29 drives L1 support reporting
// - Bits 27 to 22 read zero
// - Scale field picks 1, 0.1, 0.01, 0.001
// - Value times scale gives minimum power
// - Nonzero value compares against slot limits
// - Zero value skips comparison entirely
// - Fields loaded from EEPROM, cleared by reset
// - Override field decides comparison response

`define GPC_CTRL_OFFSET     8'hb8
`define GPC_BIT_RSVD31      31
`define GPC_BIT_PLL_OFF     30
`define GPC_BIT_L1_ALLOW    29
`define GPC_BIT_DIAG        28
`define GPC_SCALE_HI        21
`define GPC_SCALE_LO        20
`define GPC_VALUE_HI        19
`define GPC_VALUE_LO        12
`define GPC_OVR_HI          11
`define GPC_OVR_LO          10
`define GPC_WRITE_MASK      32'h703f_fc00
`define GPC_RESET_VALUE     32'h0000_0000
`define GPC_LIMIT_W         8
`define GPC_MILLI_W         20
`endif

//--- gpc_cmp_if.sv
`timescale 1ns/1ps
// Carries the programmed minimum and the limit under compare to the comparator
interface gpc_cmp_if;
  logic                   start;
  logic [7:0]             min_value;
  gpc_pkg::gpc_scale_t    min_scale;
  logic [7:0]             lim_value;
  gpc_pkg::gpc_scale_t    lim_scale;
  logic                   done;
  logic                   over;

  modport ctrl (output start, output min_value, output min_scale,
                output lim_value, output lim_scale, input done, input over);
  modport cmp  (input start, input min_value, input min_scale,
                input lim_value, input lim_scale, output done, output over);
endinterface : gpc_cmp_if

//--- gpc_global_ctrl.sv
`timescale 1ns/1ps
`include "gpc_cfg.svh"
// Global chip control upper bits plus the override field they feed
module gpc_global_ctrl (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_wr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  input  wire logic        eeprom_load,
  input  wire logic [31:0] eeprom_data,
  input  wire logic        dstate_l1,
  input  wire logic        aspm_l1,
  input  wire logic        slot_limit_valid,
  input  wire logic [7:0]  slot_limit_value,
  input  wire logic [1:0]  slot_limit_scale,
  output logic             pll_off,
  output logic             active_l1_allow,
  output logic             link_cap_l1_support,
  output logic             power_over,
  output logic             power_ur_mode
);
  logic [31:0]          ctrl_reg;
  logic [31:0]          ctrl_next;
  logic [7:0]           lim_value_reg;
  gpc_pkg::gpc_scale_t  lim_scale_reg;
  logic                 busy_reg;
  logic                 over_reg;
  logic                 pll_off_reg;
  logic                 pend_reg;
  logic [7:0]           pend_value_reg;
  logic [1:0]           pend_scale_reg;
  logic [31:0]          be_mask;
  gpc_pkg::gpc_ovr_t    ovr;
  gpc_cmp_if            cmp_bus ();

  // Expands byte enables to a bit mask
  function automatic logic [31:0] gpc_be_mask(input logic [3:0] be);
    gpc_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : gpc_be_mask

  ////////////////////////////////////////////////////////////////////////////
  // Register write path
  assign be_mask = gpc_be_mask(cfg_be);

  // EEPROM load takes priority over a same-cycle config write
  always_comb begin
    ctrl_next = ctrl_reg;
    if (eeprom_load) begin
      ctrl_next = eeprom_data & `GPC_WRITE_MASK;
    end else if (cfg_wr && cfg_addr == `GPC_CTRL_OFFSET) begin
      ctrl_next = (ctrl_reg & ~(be_mask & `GPC_WRITE_MASK))
                | (cfg_wdata & be_mask & `GPC_WRITE_MASK);
    end
  end

  // Fundamental reset clears all fields
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `GPC_RESET_VALUE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Reserved bits never stored, so they read zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_addr == `GPC_CTRL_OFFSET) begin
      cfg_rdata <= ctrl_reg & `GPC_WRITE_MASK;
    end else begin
      cfg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power controls
  // Registered so PLL gating never glitches on state decode
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pll_off_reg <= 1'b0;
    end else begin
      pll_off_reg <= dstate_l1 | (aspm_l1 & ctrl_reg[`GPC_BIT_PLL_OFF]);
    end
  end
  assign pll_off = pll_off_reg;

  assign active_l1_allow     = ctrl_reg[`GPC_BIT_L1_ALLOW];
  assign link_cap_l1_support = ctrl_reg[`GPC_BIT_L1_ALLOW];

  ////////////////////////////////////////////////////////////////////////////
  // Slot power comparison
  // A message arriving mid-compare is held and run next; later ones overwrite it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg       <= 1'b0;
      pend_value_reg <= 8'h00;
      pend_scale_reg <= 2'h0;
    end else if (slot_limit_valid) begin
      pend_reg       <= 1'b1;
      pend_value_reg <= slot_limit_value;
      pend_scale_reg <= slot_limit_scale;
    end else if (!busy_reg) begin
      pend_reg       <= 1'b0;
    end
  end

  // Starts a compare only with a nonzero minimum value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg      <= 1'b0;
      lim_value_reg <= 8'h00;
      lim_scale_reg <= gpc_pkg::GPC_SCALE_1_0;
    end else if (!busy_reg && pend_reg
                 && ctrl_reg[`GPC_VALUE_HI:`GPC_VALUE_LO] != 8'h00) begin
      busy_reg      <= 1'b1;
      lim_value_reg <= pend_value_reg;
      lim_scale_reg <= gpc_pkg::gpc_scale_t'(pend_scale_reg);
    end else if (cmp_bus.done) begin
      busy_reg      <= 1'b0;
    end
  end

  assign cmp_bus.start     = busy_reg & !cmp_bus.done;
  assign cmp_bus.min_value = ctrl_reg[`GPC_VALUE_HI:`GPC_VALUE_LO];
  assign cmp_bus.min_scale = gpc_pkg::gpc_scale_t'(ctrl_reg[`GPC_SCALE_HI:`GPC_SCALE_LO]);
  assign cmp_bus.lim_value = lim_value_reg;
  assign cmp_bus.lim_scale = lim_scale_reg;

  gpc_power_cmp u_cmp (
    .clock (clock),
    .rst_b (rst_b),
    .cmp   (cmp_bus)
  );

  // Result held until next message; zero minimum drops any prior result
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      over_reg <= 1'b0;
    end else if (ctrl_reg[`GPC_VALUE_HI:`GPC_VALUE_LO] == 8'h00) begin
      over_reg <= 1'b0;
    end else if (cmp_bus.done) begin
      over_reg <= cmp_bus.over;
    end
  end

  // Reserved override code acts as ignore
  assign ovr           = gpc_pkg::gpc_ovr_t'(ctrl_reg[`GPC_OVR_HI:`GPC_OVR_LO]);
  assign power_over    = over_reg & (ovr == gpc_pkg::GPC_OVR_PIN
                                  || ovr == gpc_pkg::GPC_OVR_PIN_UR);
  assign power_ur_mode = over_reg & (ovr == gpc_pkg::GPC_OVR_PIN_UR);
endmodule : gpc_global_ctrl

//--- gpc_global_ctrl_assertions.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Watches reserved bits, PLL gating, L1 reporting and power outputs
module gpc_global_ctrl_chk (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata,
  input wire logic        eeprom_load,
  input wire logic [31:0] eeprom_data,
  input wire logic        dstate_l1,
  input wire logic        aspm_l1,
  input wire logic        pll_off,
  input wire logic        active_l1_allow,
  input wire logic        link_cap_l1_support,
  input wire logic        power_over,
  input wire logic        power_ur_mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  rsvd_top_a:
    assert property (cfg_rdata[31] == 1'b0) else $error("bit 31 read nonzero");
  rsvd_mid_a:
    assert property (cfg_rdata[27:22] == 6'h00) else $error("bits 27 to 22 nonzero");
  rsvd_low_a:
    assert property (cfg_rdata[9:0] == 10'h000) else $error("bits 9 to 0 nonzero");
  cap_follows_a:
    assert property (active_l1_allow == link_cap_l1_support) else $error("L1 report differs");
  dstate_pll_a:
    assert property (dstate_l1 |=> pll_off) else $error("PLL kept on in device L1");
  no_l1_pll_a:
    assert property (!dstate_l1 && !aspm_l1 |=> !pll_off) else $error("PLL off outside L1");
  ur_needs_over_a:
    assert property (power_ur_mode |-> power_over) else $error("UR mode without over");
  eeprom_image_a:
    assert property (eeprom_load && cfg_addr == 8'hb8 ##1 cfg_addr == 8'hb8
      |=> cfg_rdata == ($past(eeprom_data, 2) & 32'h703f_fc00)) else $error("load lost");
endmodule : gpc_global_ctrl_chk

bind gpc_global_ctrl gpc_global_ctrl_chk i_chk (.clock(clock), .rst_b(rst_b),
  .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .eeprom_load(eeprom_load),
  .eeprom_data(eeprom_data), .dstate_l1(dstate_l1), .aspm_l1(aspm_l1), .pll_off(pll_off),
  .active_l1_allow(active_l1_allow), .link_cap_l1_support(link_cap_l1_support),
  .power_over(power_over), .power_ur_mode(power_ur_mode));

//--- gpc_msg_src.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Upstream partner: slot power limit messages as one-cycle pulses
module gpc_msg_src (
  input  wire logic clock,
  output logic       slot_limit_valid,
  output logic [7:0] slot_limit_value,
  output logic [1:0] slot_limit_scale
);
  initial begin
    slot_limit_valid = 1'b0;
    slot_limit_value = 8'h00;
    slot_limit_scale = 2'h0;
  end
  // Fields flip after the pulse so a stale limit never looks fresh
  task send(input logic [7:0] v, input logic [1:0] s);
    @(negedge clock);
    slot_limit_valid = 1'b1;
    slot_limit_value = v;
    slot_limit_scale = s;
    @(negedge clock);
    slot_limit_valid = 1'b0;
    slot_limit_value = ~v;
    slot_limit_scale = ~s;
  endtask : send
endmodule : gpc_msg_src

//--- gpc_pkg.sv
package gpc_pkg;
  typedef enum logic [1:0] {
    GPC_SCALE_1_0,
    GPC_SCALE_0_1,
    GPC_SCALE_0_01,
    GPC_SCALE_0_001
  } gpc_scale_t;

  typedef enum logic [1:0] {
    GPC_OVR_IGNORE,
    GPC_OVR_PIN,
    GPC_OVR_PIN_UR,
    GPC_OVR_RSVD
  } gpc_ovr_t;

  typedef enum logic [1:0] {
    GPC_CMP_IDLE,
    GPC_CMP_CALC,
    GPC_CMP_DONE
  } gpc_cmp_state_t;
endpackage : gpc_pkg

//--- gpc_power_cmp.sv
`timescale 1ns/1ps
`include "gpc_cfg.svh"
// Scaled power comparison, two cycles after start
module gpc_power_cmp (
  input  wire logic clock,
  input  wire logic rst_b,
  gpc_cmp_if.cmp    cmp
);
  gpc_pkg::gpc_cmp_state_t state_reg;
  logic [`GPC_MILLI_W-1:0] min_milli_reg;
  logic [`GPC_MILLI_W-1:0] lim_milli_reg;
  logic                    over_reg;

  // Converts value and scale to milliwatts so both sides compare exactly
  function automatic logic [`GPC_MILLI_W-1:0] gpc_to_milli(
    input logic [7:0] value, input gpc_pkg::gpc_scale_t scale);
    logic [`GPC_MILLI_W-1:0] v;
    v = {12'h000, value};
    case (scale)
      gpc_pkg::GPC_SCALE_1_0:  gpc_to_milli = `GPC_MILLI_W'(v * 20'd1000);
      gpc_pkg::GPC_SCALE_0_1:  gpc_to_milli = `GPC_MILLI_W'(v * 20'd100);
      gpc_pkg::GPC_SCALE_0_01: gpc_to_milli = `GPC_MILLI_W'(v * 20'd10);
      default:                 gpc_to_milli = v;
    endcase
  endfunction : gpc_to_milli

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= gpc_pkg::GPC_CMP_IDLE;
    end else begin
      case (state_reg)
        gpc_pkg::GPC_CMP_IDLE: if (cmp.start) state_reg <= gpc_pkg::GPC_CMP_CALC;
        gpc_pkg::GPC_CMP_CALC: state_reg <= gpc_pkg::GPC_CMP_DONE;
        default:               state_reg <= gpc_pkg::GPC_CMP_IDLE;
      endcase
    end
  end

  // Operand capture; split from compare to keep multiplier path short
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      min_milli_reg <= '0;
      lim_milli_reg <= '0;
    end else if (state_reg == gpc_pkg::GPC_CMP_IDLE && cmp.start) begin
      min_milli_reg <= gpc_to_milli(cmp.min_value, cmp.min_scale);
      lim_milli_reg <= gpc_to_milli(cmp.lim_value, cmp.lim_scale);
    end
  end

  // Over when the slot limit exceeds the required minimum
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      over_reg <= 1'b0;
    end else if (state_reg == gpc_pkg::GPC_CMP_CALC) begin
      over_reg <= (lim_milli_reg > min_milli_reg);
    end
  end

  assign cmp.done = (state_reg == gpc_pkg::GPC_CMP_DONE);
  assign cmp.over = over_reg;
endmodule : gpc_power_cmp

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clock, rst_b, cfg_wr, eeprom_load, dstate_l1, aspm_l1, slot_limit_valid;
  logic        pll_off, active_l1_allow, link_cap_l1_support, power_over, power_ur_mode;
  logic [7:0]  cfg_addr, slot_limit_value;
  logic [3:0]  cfg_be;
  logic [1:0]  slot_limit_scale;
  logic [31:0] cfg_wdata, cfg_rdata, eeprom_data;
  int          bad_count, samples_checked;
  gpc_global_ctrl i_gpc_global_ctrl (
    .clock               (clock),
    .rst_b               (rst_b),
    .cfg_addr            (cfg_addr),
    .cfg_wr              (cfg_wr),
    .cfg_be              (cfg_be),
    .cfg_wdata           (cfg_wdata),
    .cfg_rdata           (cfg_rdata),
    .eeprom_load         (eeprom_load),
    .eeprom_data         (eeprom_data),
    .dstate_l1           (dstate_l1),
    .aspm_l1             (aspm_l1),
    .slot_limit_valid    (slot_limit_valid),
    .slot_limit_value    (slot_limit_value),
    .slot_limit_scale    (slot_limit_scale),
    .pll_off             (pll_off),
    .active_l1_allow     (active_l1_allow),
    .link_cap_l1_support (link_cap_l1_support),
    .power_over          (power_over),
    .power_ur_mode       (power_ur_mode)
  );
  gpc_msg_src i_gpc_msg_src (.clock(clock), .slot_limit_valid(slot_limit_valid),
    .slot_limit_value(slot_limit_value), .slot_limit_scale(slot_limit_scale));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Writes land at the posedge inside the task; inputs move on falling edges
  task wr(input logic [31:0] d, input logic [3:0] be);
    @(negedge clock);
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge clock);
    cfg_wr = 1'b0;
  endtask : wr
  task rd_chk(input logic [31:0] exp);
    @(negedge clock);
    check(cfg_rdata, exp);
  endtask : rd_chk
  // Compare finishes about four cycles after the message; eight leaves margin
  task msg(input logic [7:0] v, input logic [1:0] s, input logic ov, input logic ur);
    i_gpc_msg_src.send(v, s);
    repeat (8) @(negedge clock);
    check({31'h0, power_over}, {31'h0, ov});
    check({31'h0, power_ur_mode}, {31'h0, ur});
  endtask : msg
  ////////////////////////////////////////////////////////////////////////////////
  task t_access;
    rd_chk(32'h0000_0000);
    wr(32'hefff_ffff, 4'hf);
    rd_chk(32'h603f_fc00);
    check({31'h0, link_cap_l1_support}, 32'h1);
    check({31'h0, active_l1_allow}, 32'h1);
    wr(32'h0000_0000, 4'h4);
    rd_chk(32'h6000_fc00);
    cfg_addr = 8'hb4;
    rd_chk(32'h0000_0000);
    // A write at another offset must leave the control word alone
    wr(32'h0000_0000, 4'hf);
    cfg_addr = 8'hb8;
    rd_chk(32'h6000_fc00);
    wr(32'h0000_0000, 4'hf);
    check({31'h0, active_l1_allow}, 32'h0);
  endtask : t_access
  task t_pll;
    wr(32'h4000_0000, 4'hf);
    aspm_l1 = 1'b1;
    repeat (2) @(negedge clock);
    check({31'h0, pll_off}, 32'h1);
    wr(32'h0000_0000, 4'hf);
    repeat (2) @(negedge clock);
    check({31'h0, pll_off}, 32'h0);
    dstate_l1 = 1'b1;
    repeat (2) @(negedge clock);
    check({31'h0, pll_off}, 32'h1);
    dstate_l1 = 1'b0;
    aspm_l1 = 1'b0;
  endtask : t_pll
  task t_power;
    wr(32'h0000_a400, 4'hf);
    msg(8'd25, 2'h0, 1'b1, 1'b0);
    msg(8'd5, 2'h0, 1'b0, 1'b0);
    // Second message lands mid-compare; the held one must still be run
    i_gpc_msg_src.send(8'd5, 2'h0);
    msg(8'd25, 2'h0, 1'b1, 1'b0);
    wr(32'h0000_a000, 4'hf);
    check({31'h0, power_over}, 32'h0);
    wr(32'h0000_ac00, 4'hf);
    msg(8'd25, 2'h0, 1'b0, 1'b0);
    wr(32'h0000_a800, 4'hf);
    msg(8'd25, 2'h0, 1'b1, 1'b1);
    wr(32'h0016_4400, 4'hf);
    msg(8'd10, 2'h0, 1'b0, 1'b0);
    msg(8'd101, 2'h1, 1'b1, 1'b0);
    wr(32'h0020_1400, 4'hf);
    msg(8'd9, 2'h3, 1'b0, 1'b0);
    msg(8'd11, 2'h3, 1'b1, 1'b0);
    wr(32'h0030_1400, 4'hf);
    msg(8'd2, 2'h3, 1'b1, 1'b0);
    wr(32'h0000_0400, 4'hf);
    msg(8'd250, 2'h0, 1'b0, 1'b0);
  endtask : t_power
  // Load and config write in one cycle: the image must win
  task t_eeprom;
    @(negedge clock);
    eeprom_data = 32'hefff_ffff;
    eeprom_load = 1'b1;
    cfg_be = 4'hf;
    cfg_wdata = 32'h0000_0000;
    cfg_wr = 1'b1;
    @(negedge clock);
    eeprom_load = 1'b0;
    cfg_wr = 1'b0;
    rd_chk(32'h603f_fc00);
    rst_b = 1'b0;
    @(negedge clock);
    rst_b = 1'b1;
    rd_chk(32'h0000_0000);
    check({31'h0, active_l1_allow}, 32'h0);
  endtask : t_eeprom
  task print_verdict;
    $display("checks=%0d errors=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    {rst_b, cfg_wr, eeprom_load, dstate_l1, aspm_l1, cfg_be} = '0;
    {cfg_wdata, eeprom_data} = '0;
    cfg_addr = 8'hb8;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    t_access();
    t_pll();
    t_power();
    t_eeprom();
    print_verdict();
  end
endmodule : tb_top
